// File: inc/rlsc_pkg.sv
package rlsc_pkg;
   localparam int WORD_W  = 16;
   localparam int PC_W    = 15;
   localparam int HALF_W  = 8;
   localparam int ZGRP_W  = 4;
   // Timing chain
   localparam int CLK_NS       = 20;
   localparam int MINOR_NS     = 100;
   localparam int SETTLE_NS    = 50;
   localparam int CLEAR_NS     = 25;
   localparam int PHASE_STEPS  = MINOR_NS / CLK_NS;
   localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CLEAR_CYC    = (CLEAR_NS / CLK_NS < 1) ? 1 : CLEAR_NS / CLK_NS;
   localparam logic [2:0] T00_STEP  = 3'h0;
   localparam logic [2:0] T25_STEP  = 3'(CLEAR_CYC);
   localparam logic [2:0] T50_STEP  = 3'(PHASE_STEPS - SETTLE_CYC);
   localparam logic [2:0] LAST_STEP = 3'(PHASE_STEPS - 1);
   localparam logic [1:0] EARLY_MINOR = 2'h0;
   localparam logic [1:0] MID_MINOR   = 2'h1;
   localparam logic [1:0] LATE_MINOR  = 2'h2;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CMD_OFS    = 8'h04;
   localparam logic [7:0] ACC_OFS    = 8'h08;
   localparam logic [7:0] AUX_OFS    = 8'h0C;
   localparam logic [7:0] PC_OFS     = 8'h10;
   localparam logic [7:0] OPND_OFS   = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   // Control register fields
   localparam int CYC_LO = 0;
   localparam int CYC_HI = 1;
   localparam int READ_OPERAND_BIT = 2;
   localparam int STORE_BIT        = 3;
   localparam int REG_REF_BIT      = 4;
   localparam int CHAR_BIT         = 5;
   localparam int INSTR_LO         = 6;
   localparam int INSTR_HI         = 9;
   localparam int ACC_DEST_BIT     = 10;
   localparam int PARITY_BIT       = 11;
   localparam int CON_AUX_BIT      = 12;
   localparam int AUX_TO_ADD_BIT   = 13;
   localparam int CON_PC_BIT       = 14;
   localparam int PC_TO_ADD_BIT    = 15;
   localparam int CON_OPND_BIT     = 16;
   localparam int OPND_TO_ADD_BIT  = 17;
   localparam int AUX_EARLY_BIT    = 18;
   localparam int AUX_LATE_BIT     = 19;
   localparam int PC_EARLY_BIT     = 20;
   localparam int PC_ADVANCE_BIT   = 21;
   localparam int OPND_EARLY_BIT   = 22;
   localparam int OPND_MID_BIT     = 23;
   localparam int OPND_LATE_BIT    = 24;
   localparam int DIV_STEP_BIT     = 25;
   // Command register fields
   localparam int MAN_CLEAR_BIT = 0;
   localparam int MEM_READ_BIT  = 1;
   localparam int MEM_WRITE_BIT = 2;
   // Major cycles
   localparam logic [1:0] CYC_NONE = 2'h0;
   localparam logic [1:0] CYC_A    = 2'h1;
   localparam logic [1:0] CYC_B    = 2'h2;
   localparam logic [1:0] CYC_C    = 2'h3;
   // Instruction codes
   localparam logic [3:0] INS_NONE      = 4'h0;
   localparam logic [3:0] INS_MULTIPLY  = 4'h1;
   localparam logic [3:0] INS_DIVIDE    = 4'h2;
   localparam logic [3:0] INS_ENTER_ACC = 4'h3;
   localparam logic [3:0] INS_INCR_ACC  = 4'h4;
   localparam logic [3:0] INS_INTER_REG = 4'h5;
   localparam logic [3:0] INS_LOAD_ACC  = 4'h6;
   localparam logic [3:0] INS_ADD       = 4'h7;
   localparam logic [3:0] INS_LOG_PROD  = 4'h8;
   localparam logic [3:0] INS_EXCL_OR   = 4'h9;
   localparam logic [3:0] INS_SUBTRACT  = 4'hA;
   localparam logic [3:0] INS_STORE_PAR = 4'hB;
   localparam logic [3:0] INS_INPUT     = 4'hC;
   localparam logic [3:0] INS_SKIP      = 4'hD;
   typedef enum logic [1:0] {ACC_FROM_ADDER, ACC_FROM_MAG, ACC_FROM_ONE} rlsc_acc_src_t;
endpackage

// File: hw/rlsc_sync.sv
`timescale 1ns/1ps
module rlsc_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } rlsc_sync_state_t;

   rlsc_sync_state_t s;
   rlsc_sync_state_t next_s;

   // Output follows only once second and third stage agree
   always_comb begin
      next_s    = s;
      next_s.s1 = async_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      if (s.s2 == s.s3) begin
         next_s.q = s.s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.q;
endmodule

// File: hw/rlsc_core.sv
`timescale 1ns/1ps
module rlsc_core (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic [rlsc_pkg::WORD_W-1:0]  adder_result,
   input  wire logic [rlsc_pkg::WORD_W-1:0]  input_word,
   input  wire logic [rlsc_pkg::WORD_W-1:0]  storage_data,
   input  wire logic                         end_around_borrow,
   input  wire logic                         storage_resume,
   input  wire logic                         device_reject,
   input  wire logic                         master_clear,
   output logic [rlsc_pkg::WORD_W-1:0]       accumulator,
   output logic [rlsc_pkg::WORD_W-1:0]       aux_register,
   output logic [rlsc_pkg::PC_W-1:0]         program_counter,
   output logic [rlsc_pkg::WORD_W-1:0]       operand_register,
   output logic [rlsc_pkg::WORD_W-1:0]       operand_to_adder,
   output logic [7:0]                        zero_groups,
   output logic                              mem_request,
   output logic                              resume_active
);
   import rlsc_pkg::*;

   typedef struct packed {
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
      logic [31:0]         ctrl;
      logic                mem_request;
      logic                mem_write;
      logic [2:0]          step;
      logic [1:0]          minor;
      logic                acc_sel;
      rlsc_acc_src_t       acc_src;
      logic                input_sel;
      logic                aux_sel;
      logic                pc_sel;
      logic                opnd_sel;
      logic                resume;
      logic                resume_armed;
      logic [WORD_W-1:0]   acc;
      logic [WORD_W-1:0]   aux;
      logic [PC_W-1:0]     pc;
      logic [WORD_W-1:0]   opnd;
      logic [WORD_W-1:0]   opnd_out;
      logic [7:0]          zero_groups;
   } rlsc_state_t;

   rlsc_state_t s;
   rlsc_state_t next_s;

   logic resume_sync;
   logic reject_sync;
   logic mclear_sync;

   rlsc_sync u_resume_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (storage_resume),
      .sync_out (resume_sync)
   );

   rlsc_sync u_reject_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (device_reject),
      .sync_out (reject_sync)
   );

   rlsc_sync u_mclear_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (master_clear),
      .sync_out (mclear_sync)
   );

   logic       t00;
   logic       t25;
   logic       t50;
   logic       early_set_strobe;
   logic       mid_set_strobe;
   logic       late_set_strobe;
   logic [1:0] cyc;
   logic [3:0] instr;
   logic       read_operand_mode;
   logic       store_mode;
   logic       reg_ref_mode;
   logic       char_mode;
   logic       mul_div;
   logic       arith_instr;
   logic       man_clear;
   logic       divide_step;
   logic       acc_mag_gate;
   logic       acc_adder_gate;
   logic       acc_one_gate;

   always_comb begin
      next_s = s;
      // Phase strobes from the free-running chain
      t00 = (s.step == T00_STEP);
      t25 = (s.step == T25_STEP);
      t50 = (s.step == T50_STEP);
      early_set_strobe = t50 && (s.minor == EARLY_MINOR);
      mid_set_strobe   = t50 && (s.minor == MID_MINOR);
      late_set_strobe  = t50 && (s.minor == LATE_MINOR);
      if (s.step == LAST_STEP) begin
         next_s.step  = T00_STEP;
         next_s.minor = s.minor + 2'h1;
      end else begin
         next_s.step = s.step + 3'h1;
      end

      // Control word fields
      cyc               = s.ctrl[CYC_HI:CYC_LO];
      instr             = s.ctrl[INSTR_HI:INSTR_LO];
      read_operand_mode = s.ctrl[READ_OPERAND_BIT];
      store_mode        = s.ctrl[STORE_BIT];
      reg_ref_mode      = s.ctrl[REG_REF_BIT];
      char_mode         = s.ctrl[CHAR_BIT];
      divide_step       = s.ctrl[DIV_STEP_BIT];
      mul_div           = (instr == INS_MULTIPLY) || (instr == INS_DIVIDE);
      arith_instr       = (instr == INS_LOAD_ACC) || (instr == INS_ADD) || (instr == INS_LOG_PROD)
                          || (instr == INS_EXCL_OR) || (instr == INS_SUBTRACT);
      man_clear         = 1'b0;

      // APB: request taken, answered one cycle later
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      if (psel && penable && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.prdata = 32'h00000000;
         case (paddr)
            CTRL_OFS:   next_s.prdata = s.ctrl;
            CMD_OFS:    next_s.prdata = 32'h00000000;
            ACC_OFS:    next_s.prdata = {16'h0000, s.acc};
            AUX_OFS:    next_s.prdata = {16'h0000, s.aux};
            PC_OFS:     next_s.prdata = {17'h00000, s.pc};
            OPND_OFS:   next_s.prdata = {16'h0000, s.opnd};
            STATUS_OFS: next_s.prdata = {8'h00, s.zero_groups, 3'h0, s.step, s.minor, s.mem_write,
                                         s.mem_request, s.resume, s.opnd_sel, s.pc_sel, s.aux_sel,
                                         s.input_sel, s.acc_sel};
            default:    next_s.pslverr = 1'b1;
         endcase
         if (pwrite && (paddr != CTRL_OFS) && (paddr != CMD_OFS)) begin
            next_s.pslverr = 1'b1;
         end
      end

      // Writes land on the edge that sees pready high
      if (psel && penable && s.pready && pwrite) begin
         if (paddr == CTRL_OFS) begin
            next_s.ctrl = pwdata;
         end
         if (paddr == CMD_OFS) begin
            man_clear = pwdata[MAN_CLEAR_BIT];
         end
      end

      // Accumulator select gates
      acc_mag_gate   = late_set_strobe && mul_div && read_operand_mode && (cyc == CYC_B);
      acc_one_gate   = late_set_strobe && (instr == INS_STORE_PAR) && (cyc == CYC_A)
                       && store_mode && s.ctrl[PARITY_BIT];
      acc_adder_gate = 1'b0;
      if (mid_set_strobe && mul_div && read_operand_mode && ((cyc == CYC_B) || (cyc == CYC_C))) begin
         acc_adder_gate = 1'b1;
      end
      if (late_set_strobe && mul_div && read_operand_mode && (cyc == CYC_C)) begin
         acc_adder_gate = 1'b1;
      end
      if (late_set_strobe && (cyc == CYC_A) && reg_ref_mode
          && ((instr == INS_ENTER_ACC) || (instr == INS_INCR_ACC))) begin
         acc_adder_gate = 1'b1;
      end
      if (late_set_strobe && (cyc == CYC_A) && (instr == INS_INTER_REG) && s.ctrl[ACC_DEST_BIT]) begin
         acc_adder_gate = 1'b1;
      end
      if (late_set_strobe && (cyc == CYC_B) && arith_instr) begin
         acc_adder_gate = 1'b1;
      end

      // Select flip-flops clear at quarter phase, set at half phase
      if (t25) begin
         next_s.acc_sel   = 1'b0;
         next_s.input_sel = 1'b0;
         next_s.aux_sel   = 1'b0;
         next_s.pc_sel    = 1'b0;
         next_s.opnd_sel  = 1'b0;
         next_s.resume    = 1'b0;
      end

      // Accumulator source, magnitude over +1 over adder
      if (acc_mag_gate) begin
         next_s.acc_sel = 1'b1;
         next_s.acc_src = ACC_FROM_MAG;
      end else if (acc_one_gate) begin
         next_s.acc_sel = 1'b1;
         next_s.acc_src = ACC_FROM_ONE;
      end else if (acc_adder_gate) begin
         next_s.acc_sel = 1'b1;
         next_s.acc_src = ACC_FROM_ADDER;
      end

      // Input select, held off by a reject
      if (late_set_strobe && (cyc == CYC_A) && (instr == INS_INPUT) && !reject_sync) begin
         next_s.input_sel = 1'b1;
      end

      // Auxiliary, program-counter and operand select gates
      if ((t50 && s.ctrl[CON_AUX_BIT] && s.ctrl[AUX_TO_ADD_BIT])
          || (early_set_strobe && (cyc == CYC_C) && s.ctrl[AUX_EARLY_BIT])
          || (late_set_strobe && s.ctrl[AUX_LATE_BIT])) begin
         next_s.aux_sel = 1'b1;
      end
      if ((t50 && s.ctrl[CON_PC_BIT] && s.ctrl[PC_TO_ADD_BIT])
          || (early_set_strobe && (cyc == CYC_B) && s.ctrl[PC_EARLY_BIT])
          || (late_set_strobe && s.ctrl[PC_ADVANCE_BIT])) begin
         next_s.pc_sel = 1'b1;
      end
      if ((t50 && s.ctrl[CON_OPND_BIT] && s.ctrl[OPND_TO_ADD_BIT])
          || (early_set_strobe && (cyc == CYC_B) && s.ctrl[OPND_EARLY_BIT])
          || (mid_set_strobe && s.ctrl[OPND_MID_BIT])
          || (late_set_strobe && s.ctrl[OPND_LATE_BIT])) begin
         next_s.opnd_sel = 1'b1;
      end

      // Storage handshake; a resume left from the last transfer must fall first
      if (!resume_sync) begin
         next_s.resume_armed = 1'b1;
      end
      if (t50 && resume_sync && s.mem_request && s.resume_armed) begin
         next_s.resume_armed = 1'b0;
         next_s.mem_request  = 1'b0;
         if (!s.mem_write) begin
            next_s.resume = 1'b1;
         end
      end
      if (psel && penable && s.pready && pwrite && (paddr == CMD_OFS)
          && (pwdata[MEM_READ_BIT] || pwdata[MEM_WRITE_BIT])) begin
         next_s.mem_request = 1'b1;
         next_s.mem_write   = pwdata[MEM_WRITE_BIT];
      end

      // Phase-zero loads
      if (t00) begin
         if (s.acc_sel) begin
            case (s.acc_src)
               ACC_FROM_MAG:   next_s.acc = s.acc[WORD_W-1] ? ~s.acc : s.acc;
               ACC_FROM_ONE:   next_s.acc = 16'h0001;
               default:        next_s.acc = adder_result;
            endcase
         end else if (s.input_sel) begin
            if (char_mode) begin
               next_s.acc = {s.acc[WORD_W-1:HALF_W], input_word[HALF_W-1:0]};
            end else begin
               next_s.acc = input_word;
            end
         end
         if (s.aux_sel && !(divide_step && end_around_borrow)) begin
            next_s.aux = adder_result;
         end
         if (s.pc_sel) begin
            next_s.pc = adder_result[PC_W-1:0];
         end
         if (s.resume) begin
            next_s.opnd = storage_data;
         end else if (s.opnd_sel) begin
            next_s.opnd = adder_result;
         end
      end
      if (man_clear || mclear_sync) begin
         next_s.aux = 16'h0000;
         next_s.pc  = 15'h0000;
      end

      // Operand toward adder with skip masking
      next_s.opnd_out = next_s.opnd;
      if ((instr == INS_SKIP) && reg_ref_mode) begin
         next_s.opnd_out[7:4] = 4'h0;
      end

      // Zero groups for the skip logic
      for (int g = 0; g < 4; g++) begin
         next_s.zero_groups[g]     = (next_s.acc[g*ZGRP_W +: ZGRP_W] == 4'h0);
         next_s.zero_groups[g + 4] = (next_s.aux[g*ZGRP_W +: ZGRP_W] == 4'h0);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s             <= '0;
         s.ctrl        <= CTRL_RESET;
         s.acc_src     <= ACC_FROM_ADDER;
         s.zero_groups <= 8'hFF;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign prdata           = s.prdata;
   assign pready           = s.pready;
   assign pslverr          = s.pslverr;
   assign accumulator      = s.acc;
   assign aux_register     = s.aux;
   assign program_counter  = s.pc;
   assign operand_register = s.opnd;
   assign operand_to_adder = s.opnd_out;
   assign zero_groups      = s.zero_groups;
   assign mem_request      = s.mem_request;
   assign resume_active    = s.resume;
endmodule

// File: tb/rlsc_storage_model.sv
`timescale 1ns/1ps
// Storage unit and input receivers facing the load-select block
module rlsc_storage_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        mem_request,
   input  wire logic [7:0]  delay,
   input  wire logic [15:0] data,
   input  wire logic [15:0] in_word,
   input  wire logic        reject,
   output logic             storage_resume,
   output logic [15:0]      storage_data,
   output logic [15:0]      input_word,
   output logic             device_reject
);
   logic [7:0] cnt;
   // Answers a request after delay cycles, holds resume until the request drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt            <= 8'h00;
         storage_resume <= 1'b0;
         storage_data   <= 16'hFFFF;
      end else if (!mem_request) begin
         cnt            <= 8'h00;
         storage_resume <= 1'b0;
      end else if (cnt < delay) begin
         cnt          <= cnt + 8'h01;
         storage_data <= ~storage_data;
      end else begin
         storage_resume <= 1'b1;
         storage_data   <= data;
      end
   end
   assign input_word    = in_word;
   assign device_reject = reject;
endmodule

// File: tb/rlsc_core_properties.sv
`timescale 1ns/1ps
module rlsc_core_properties
   import rlsc_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] storage_data,
   input wire logic        master_clear,
   input wire logic [15:0] accumulator,
   input wire logic [15:0] aux_register,
   input wire logic [14:0] program_counter,
   input wire logic [15:0] operand_register,
   input wire logic [15:0] operand_to_adder,
   input wire logic [7:0]  zero_groups,
   input wire logic        mem_request,
   input wire logic        resume_active
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   function automatic logic [7:0] zg(logic [15:0] a, logic [15:0] x);
      for (int g = 0; g < 4; g++) begin
         zg[g]   = a[4*g +: 4] == 4'h0;
         zg[g+4] = x[4*g +: 4] == 4'h0;
      end
   endfunction
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   property p_err_unmapped;
      psel && penable && !pready && paddr > STATUS_OFS |=> pready && pslverr;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped address");
   property p_resume_hold;
      $rose(resume_active) |-> resume_active[*4] ##1 !resume_active;
   endproperty
   a_resume_hold: assert property (p_resume_hold) else $error("resume width wrong");
   property p_resume_req;
      $rose(resume_active) |-> !mem_request;
   endproperty
   a_resume_req: assert property (p_resume_req) else $error("request not dropped");
   property p_resume_load;
      $rose(resume_active) |-> ##3 operand_register == $past(storage_data);
   endproperty
   a_resume_load: assert property (p_resume_load) else $error("operand not from storage");
   property p_master_clear;
      master_clear[*7] |-> aux_register == 16'h0000 && program_counter == 15'h0000;
   endproperty
   a_master_clear: assert property (p_master_clear) else $error("master clear ignored");
   property p_zero_groups;
      $stable(accumulator) && $stable(aux_register) |-> zero_groups == zg(accumulator, aux_register);
   endproperty
   a_zero_groups: assert property (p_zero_groups) else $error("zero flags wrong");
   property p_skip_mask;
      $stable(operand_register) |-> operand_to_adder[15:8] == operand_register[15:8]
         && operand_to_adder[3:0] == operand_register[3:0];
   endproperty
   a_skip_mask: assert property (p_skip_mask) else $error("operand to adder wrong");
   property p_acc_spacing;
      $changed(accumulator) |=> $stable(accumulator)[*4];
   endproperty
   a_acc_spacing: assert property (p_acc_spacing) else $error("acc loads too close");
   property p_aux_spacing;
      $changed(aux_register) |=> $stable(aux_register)[*4];
   endproperty
   a_aux_spacing: assert property (p_aux_spacing) else $error("aux loads too close");
endmodule
bind rlsc_core rlsc_core_properties u_rlsc_core_properties (.pclk, .presetn, .psel, .penable, .paddr,
   .pready, .pslverr, .storage_data, .master_clear, .accumulator, .aux_register, .program_counter,
   .operand_register, .operand_to_adder, .zero_groups, .mem_request, .resume_active);

// File: tb/rlsc_core_tb.sv
`timescale 1ns/1ps
module rlsc_core_tb;
   import rlsc_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, zero_groups, p_delay = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, seen, storage_resume, device_reject, mem_request, resume_active;
   logic        reject = 1'b0, end_around_borrow = 1'b0, master_clear = 1'b0;
   logic [15:0] adder_result = 16'h0, in_word = 16'h0, data = 16'h0, input_word, storage_data;
   logic [15:0] accumulator, aux_register, operand_register, operand_to_adder;
   logic [14:0] program_counter;
   int          failures = 0, compares = 0;
   localparam logic [31:0] GATE [6] = '{32'h1 << CON_AUX_BIT | 32'h1 << AUX_TO_ADD_BIT,
      32'h1 << AUX_EARLY_BIT | 32'(CYC_C), 32'h1 << AUX_LATE_BIT | 32'(CYC_A),
      32'h1 << CON_PC_BIT | 32'h1 << PC_TO_ADD_BIT, 32'h1 << PC_EARLY_BIT | 32'(CYC_B),
      32'h1 << PC_ADVANCE_BIT | 32'(CYC_A)};
   localparam logic [31:0] READ_OPERAND_MODE = 32'h1 << READ_OPERAND_BIT;
   localparam logic [31:0] OPND_GATE [3] = '{32'h1 << CON_OPND_BIT | 32'h1 << OPND_TO_ADD_BIT,
      32'h1 << OPND_MID_BIT, 32'h1 << OPND_LATE_BIT};
   always #10 pclk = ~pclk;
   rlsc_core u_rlsc_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .adder_result, .input_word, .storage_data, .end_around_borrow, .storage_resume,
      .device_reject, .master_clear, .accumulator, .aux_register, .program_counter, .operand_register,
      .operand_to_adder, .zero_groups, .mem_request, .resume_active);
   rlsc_storage_model u_rlsc_storage_model (.pclk, .presetn, .mem_request, .delay(p_delay), .data,
      .in_word, .reject, .storage_resume, .storage_data, .input_word, .device_reject);
   function automatic logic [31:0] cw(logic [1:0] c, logic [3:0] i, logic [31:0] f);
      return 32'(c) | 32'(i) << INSTR_LO | f;
   endfunction
   task automatic tally_and_finish;
      if (failures == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, e, s);
      end
   endtask
   // One APB transfer; read data and error land in rd and err
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
      @(posedge pclk);
   endtask
   // Quiet the control word, change the data inputs, then apply the new control word
   task automatic run(input logic [31:0] c, input logic [15:0] a, input logic [15:0] iw = 16'h0,
                      input logic rj = 1'b0, input logic eb = 1'b0);
      apb(1'b1, CTRL_OFS, 32'h0);
      repeat (4) @(posedge pclk);
      adder_result <= a;
      in_word <= iw;
      reject <= rj;
      end_around_borrow <= eb;
      repeat (5) @(posedge pclk);
      apb(1'b1, CTRL_OFS, c);
      repeat (25) @(posedge pclk);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, CTRL_OFS, 32'h0);
      check("ctrl reset", rd, CTRL_RESET);
      apb(1'b0, STATUS_OFS, 32'h0);
      check("zero flags reset", 32'(rd[23:16]), 32'hFF);
      apb(1'b0, 8'h1C, 32'h0);
      check("unmapped error", 32'(err), 32'h1);
      apb(1'b1, ACC_OFS, 32'h1234);
      check("read-only error", 32'(err), 32'h1);
      for (int k = 0; k < 5; k++) begin
         run(cw(CYC_B, 4'(INS_LOAD_ACC + k), 0), 16'h1111 * 16'(k + 1));
         check("acc arith", 32'(accumulator), 32'h1111 * (k + 1));
      end
      for (int k = 0; k < 2; k++) begin
         run(cw(CYC_A, 4'(INS_ENTER_ACC + k), 32'h1 << REG_REF_BIT), 16'h2200 + 16'(k));
         check("acc enter", 32'(accumulator), 32'h2200 + k);
      end
      run(cw(CYC_A, INS_INTER_REG, 32'h1 << ACC_DEST_BIT), 16'h3300);
      check("acc inter", 32'(accumulator), 32'h3300);
      run(cw(CYC_A, INS_INTER_REG, 0), 16'h3301);
      check("acc no dest", 32'(accumulator), 32'h3300);
      run(cw(CYC_A, INS_STORE_PAR, 32'h1 << STORE_BIT), 16'h4400);
      check("acc parity zero", 32'(accumulator), 32'h3300);
      run(cw(CYC_A, INS_STORE_PAR, 32'h1 << STORE_BIT | 32'h1 << PARITY_BIT), 16'h4400);
      check("acc parity one", 32'(accumulator), 32'h0001);
      run(cw(CYC_A, INS_INPUT, 0), 16'h5500, 16'hC3A5);
      check("acc input", 32'(accumulator), 32'hC3A5);
      run(cw(CYC_A, INS_INPUT, 32'h1 << CHAR_BIT), 16'h5500, 16'h7E5A);
      check("acc char", 32'(accumulator), 32'hC35A);
      run(cw(CYC_A, INS_INPUT, 0), 16'h5500, 16'h0F0F, 1'b1);
      check("acc reject", 32'(accumulator), 32'hC35A);
      run(cw(CYC_C, INS_MULTIPLY, READ_OPERAND_MODE), 16'h2468);
      check("acc mul", 32'(accumulator), 32'h2468);
      run(cw(CYC_B, INS_DIVIDE, READ_OPERAND_MODE), 16'h1357);
      check("acc div", 32'(accumulator), 32'h1357);
      check("zero flags", 32'(zero_groups), 32'hF0);
      for (int j = 0; j < 6; j++) begin
         run(GATE[j], 16'h1E00 + 16'(j * 16'h0111));
         check("aux pc", j < 3 ? 32'(aux_register) : 32'(program_counter), 32'h1E00 + j * 32'h0111);
      end
      run(GATE[2] | 32'h1 << DIV_STEP_BIT, 16'h0ABC, 16'h0, 1'b0, 1'b1);
      check("aux borrow", 32'(aux_register), 32'h2022);
      run(GATE[2] | 32'h1 << DIV_STEP_BIT, 16'h0ABC);
      check("aux no borrow", 32'(aux_register), 32'h0ABC);
      master_clear <= 1'b1;
      repeat (10) @(posedge pclk);
      master_clear <= 1'b0;
      check("aux master clear", 32'(aux_register), 32'h0);
      check("pc master clear", 32'(program_counter), 32'h0);
      run(GATE[0], 16'h7777);
      run(32'h0, 16'h0);
      apb(1'b1, CMD_OFS, 32'h1 << MAN_CLEAR_BIT);
      check("aux manual clear", 32'(aux_register), 32'h0);
      for (int j = 0; j < 2; j++) begin
         data <= 16'h9C31 + 16'(j);
         p_delay <= 8'(j * 12);
         apb(1'b1, CMD_OFS, 32'h1 << MEM_READ_BIT);
         check("mem request", 32'(mem_request), 32'h1);
         repeat (40) @(posedge pclk);
         check("mem request done", 32'(mem_request), 32'h0);
         check("operand resume", 32'(operand_register), 32'h9C31 + j);
      end
      data <= 16'h0000;
      apb(1'b1, CMD_OFS, 32'h1 << MEM_WRITE_BIT);
      repeat (40) @(posedge pclk);
      check("operand write", 32'(operand_register), 32'h9C32);
      check("mem write done", 32'(mem_request), 32'h0);
      for (int j = 0; j < 3; j++) begin
         run(OPND_GATE[j], 16'h0A50 + 16'(j));
         check("operand gates", 32'(operand_register), 32'h0A50 + j);
      end
      run(32'h1 << OPND_EARLY_BIT | 32'(CYC_B), 16'hF0F7);
      check("operand adder", 32'(operand_to_adder), 32'hF0F7);
      run(cw(CYC_B, INS_SKIP, 32'h1 << REG_REF_BIT | 32'h1 << OPND_EARLY_BIT), 16'hF0F7);
      check("skip mask", 32'(operand_to_adder), 32'hF007);
      run(cw(CYC_B, INS_MULTIPLY, READ_OPERAND_MODE), 16'h8421);
      seen = 1'b0;
      repeat (25) begin
         @(posedge pclk);
         if (accumulator === 16'h7BDE) seen = 1'b1;
      end
      check("acc magnitude", 32'(seen), 32'h1);
      tally_and_finish();
   end
endmodule
